// *** rtl/srsd_regs.vh ***
// srsd_regs.vh: constants for the segment and register select decoder
// assumes inclusion by bare name from the decoder files
`ifndef SRSD_REGS_VH
`define SRSD_REGS_VH
// segment select codes
`define SRSD_SEG_EXTRA 2'h0
`define SRSD_SEG_CODE 2'h1
`define SRSD_SEG_STACK 2'h2
`define SRSD_SEG_DATA 2'h3
// prefix pattern 001ss110
`define SRSD_PFX_MASK 8'hE7
`define SRSD_PFX_VAL 8'h26
// addressing fields
`define SRSD_MOD_NODISP 2'h0
`define SRSD_MOD_REG 2'h3
`define SRSD_RM_DIRECT 3'h6
// effective address calculation time in clocks
`define SRSD_EA_CYCLES 3'h4
`endif

// *** rtl/srsd_reg_map.v ***
// srsd_reg_map.v: register field to register file select
// assumes purely combinational use inside the decoder
`timescale 1ns/1ps
module srsd_reg_map (
  // field in
  input wire width_bit,
  input wire [2:0] reg_field,
  // select out
  output wire [2:0] reg_index,
  output wire byte_sel,
  output wire high_byte
);
  assign reg_index = width_bit ? reg_field : {1'b0, reg_field[1:0]};
  assign byte_sel = ~width_bit;
  assign high_byte = ~width_bit & reg_field[2];
endmodule // srsd_reg_map

// *** rtl/srsd_decoder.v ***
// srsd_decoder.v: segment override and operand segment/register decode
// assumes opcode bytes and completion strobe come from core-clock logic
`timescale 1ns/1ps
`include "srsd_regs.vh"
// Behaviour
// - prefix 001ss110 selects extra, code, stack or data segment by ss
// - width 1 selects 16-bit registers; width 0 low then high bytes
// - frame pointer based memory operands default to stack segment
// - string destination through destination index uses extra segment
// - override never applies to the string destination operand
// - mod 00 with r/m 110 is direct 16-bit displacement address
// - effective address calculation takes 4 clocks for memory operands and string destinations, none for other register-mode operands
module srsd_decoder (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // prefix byte
  input wire byte_valid,
  input wire [7:0] byte_in,
  // instruction fields
  input wire insn_valid,
  input wire width_bit,
  input wire [2:0] reg_field,
  input wire [1:0] mod_field,
  input wire [2:0] rm_field,
  input wire string_dest,
  input wire insn_done,
  // decoded outputs
  output reg [1:0] seg_sel,
  output reg direct_disp,
  output reg frame_based,
  output reg mem_operand,
  output reg [2:0] reg_index,
  output reg byte_sel,
  output reg high_byte,
  output reg ea_busy,
  output reg ea_done,
  output reg ovr_pending
);

  // ===========================================
  // prefix recognition
  wire pfx_match;
  wire is_prefix;
  assign pfx_match = (byte_in & `SRSD_PFX_MASK) == `SRSD_PFX_VAL;
  assign is_prefix = byte_valid & pfx_match;

  // ===========================================
  // override valid flag
  // a prefix in the completion cycle wins, so the next instruction keeps it
  reg ovr_valid_reg;
  reg ovr_valid_next;
  always @* begin
    ovr_valid_next = ovr_valid_reg;
    if (is_prefix) begin
      ovr_valid_next = 1'b1;
    end else if (insn_done) begin
      ovr_valid_next = 1'b0;
    end
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      ovr_valid_reg <= 1'b0;
    end else begin
      ovr_valid_reg <= ovr_valid_next;
    end
  end

  // ===========================================
  // override segment code; a later prefix replaces an earlier one
  reg [1:0] ovr_seg_reg;
  always @(posedge clk_sys) begin
    if (rst) begin
      ovr_seg_reg <= `SRSD_SEG_DATA;
    end else if (is_prefix) begin
      ovr_seg_reg <= byte_in[4:3];
    end
  end

  // ===========================================
  // register field map
  wire [2:0] map_index;
  wire map_byte;
  wire map_high;
  srsd_reg_map u_map (
    .width_bit(width_bit),
    .reg_field(reg_field),
    .reg_index(map_index),
    .byte_sel(map_byte),
    .high_byte(map_high)
  );

  // ===========================================
  // frame pointer table, one entry per r/m code
  // r/m 010, 011 and 110 add the frame pointer in memory modes unless the mode is direct
  wire [7:0] fp_table;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_fp
      if ((g == 2) || (g == 3) || (g == 6)) begin : g_yes
        assign fp_table[g] = 1'b1;
      end else begin : g_no
        assign fp_table[g] = 1'b0;
      end
    end
  endgenerate

  // ===========================================
  // addressing class
  wire is_mem;
  wire is_direct;
  wire uses_fp;
  wire needs_ea;
  assign is_mem = mod_field != `SRSD_MOD_REG;
  assign is_direct = (mod_field == `SRSD_MOD_NODISP) && (rm_field == `SRSD_RM_DIRECT);
  assign uses_fp = is_mem & ~is_direct & fp_table[rm_field];
  assign needs_ea = is_mem | string_dest;

  // ===========================================
  // segment choice
  // string destination is tested first so no override can ever reach it
  reg [1:0] seg_next;
  always @* begin
    if (string_dest) begin
      seg_next = `SRSD_SEG_EXTRA;
    end else if (ovr_valid_reg) begin
      seg_next = ovr_seg_reg;
    end else if (uses_fp) begin
      seg_next = `SRSD_SEG_STACK;
    end else begin
      seg_next = `SRSD_SEG_DATA;
    end
  end

  // ===========================================
  // decoded segment and addressing flags, held until the next decode
  always @(posedge clk_sys) begin
    if (rst) begin
      seg_sel <= `SRSD_SEG_DATA;
      direct_disp <= 1'b0;
      frame_based <= 1'b0;
      mem_operand <= 1'b0;
    end else if (insn_valid) begin
      seg_sel <= seg_next;
      direct_disp <= is_direct;
      frame_based <= uses_fp;
      mem_operand <= needs_ea;
    end
  end

  // ===========================================
  // decoded register select, held until the next decode
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_index <= 3'h0;
      byte_sel <= 1'b0;
      high_byte <= 1'b0;
    end else if (insn_valid) begin
      reg_index <= map_index;
      byte_sel <= map_byte;
      high_byte <= map_high;
    end
  end

  // ===========================================
  // effective address timer
  // a new request restarts it; overlapping requests stretch busy, none queue
  reg [2:0] ea_cnt_reg;
  reg [2:0] ea_cnt_next;
  reg ea_busy_next;
  reg ea_done_next;
  always @* begin
    ea_cnt_next = ea_cnt_reg;
    ea_busy_next = ea_busy;
    ea_done_next = 1'b0;
    if (insn_valid) begin
      ea_busy_next = needs_ea;
      ea_cnt_next = needs_ea ? `SRSD_EA_CYCLES - 3'h1 : 3'h0;
    end else if (ea_busy) begin
      ea_cnt_next = ea_cnt_reg - 3'h1;
      if (ea_cnt_reg == 3'h1) begin
        ea_busy_next = 1'b0;
        ea_done_next = 1'b1;
      end
    end
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      ea_cnt_reg <= 3'h0;
      ea_busy <= 1'b0;
      ea_done <= 1'b0;
    end else begin
      ea_cnt_reg <= ea_cnt_next;
      ea_busy <= ea_busy_next;
      ea_done <= ea_done_next;
    end
  end

  // ===========================================
  // pending flag, a registered copy of the override flag for outside use
  always @(posedge clk_sys) begin
    if (rst) begin
      ovr_pending <= 1'b0;
    end else begin
      ovr_pending <= ovr_valid_next;
    end
  end
endmodule // srsd_decoder

// *** test/srsd_monitor.sv ***
// srsd_monitor.sv: assertions on the decoder ports
// assumes one core clock and bind to srsd_decoder
`timescale 1ns/1ps
module srsd_monitor (
  input wire clk_sys, rst, byte_valid, insn_valid, width_bit, string_dest, insn_done,
  input wire [7:0] byte_in,
  input wire [2:0] reg_field, rm_field, reg_index,
  input wire [1:0] mod_field, seg_sel,
  input wire direct_disp, frame_based, mem_operand, byte_sel, high_byte, ea_busy, ea_done, ovr_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire pfx = byte_valid && (byte_in & 8'hE7) == 8'h26;
  ovr_seg_a:
    assert property (pfx ##1 insn_valid && !string_dest |=> seg_sel == $past(byte_in[4:3], 2)) else $error("bad seg");
  str_es_a:
    assert property (insn_valid && string_dest |=> seg_sel == 2'h0) else $error("bad str seg");
  reg_map_a:
    assert property (insn_valid |=> reg_index == ($past(width_bit) ? $past(reg_field) :
      {1'b0, $past(reg_field[1:0])})) else $error("bad index");
  byte_hi_a:
    assert property (insn_valid |=> high_byte == (!$past(width_bit) && $past(reg_field[2]))
      && byte_sel == !$past(width_bit)) else $error("bad byte");
  direct_a:
    assert property (insn_valid |=> direct_disp == ($past(mod_field) == 2'h0 && $past(rm_field) == 3'h6))
      else $error("bad direct");
  // a prefix just before the decode would select its own segment, so exclude it
  frame_ss_a:
    assert property (!byte_valid ##1 insn_valid && !ovr_pending && !string_dest && mod_field != 2'h3
      && rm_field[2:1] == 2'h1 |=> seg_sel == 2'h2 && frame_based) else $error("bad frame seg");
  ea_time_a:
    assert property (insn_valid && mod_field != 2'h3 |=> ea_busy [*3] ##1 (ea_done && !ea_busy))
      else $error("bad ea time");
  ovr_set_a:
    assert property (pfx |=> ##1 ovr_pending) else $error("no pending");
  ovr_clr_a:
    assert property (insn_done && !pfx ##1 !byte_valid |=> !ovr_pending) else $error("not cleared");
endmodule // srsd_monitor
bind srsd_decoder srsd_monitor u_mon (.*);

// *** test/testbench.sv ***
// testbench.sv: directed checks of the segment and register decoder
// assumes srsd_decoder and the bound monitor are compiled first
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 0, rst = 1, byte_valid = 0, insn_valid = 0, width_bit = 0, string_dest = 0, insn_done = 0;
  reg [7:0] byte_in = 0;
  reg [2:0] reg_field = 0, rm_field = 0;
  reg [1:0] mod_field = 0;
  wire [1:0] seg_sel;
  wire [2:0] reg_index;
  wire direct_disp, frame_based, mem_operand, byte_sel, high_byte, ea_busy, ea_done, ovr_pending;
  integer err_count = 0, num_checks = 0, i, k;
  always #5 clk_sys = ~clk_sys;
  srsd_decoder u_dut (.*);
  task wrap_up;
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input [7:0] s, e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task step; @(posedge clk_sys); #1; endtask
  task pfx(input [7:0] b); byte_valid = 1; byte_in = b; step; byte_valid = 0; endtask
  task ins(input [9:0] f);
    insn_valid = 1; {width_bit, reg_field, mod_field, rm_field, string_dest} = f; step; insn_valid = 0;
  endtask
  // bounded wait so a dead timer cannot hang the run
  task ea_wait;
    for (i = 0; i < 9 && ea_done !== 1'b1; i = i + 1) step;
    if (i == 9) begin err_count = err_count + 1; wrap_up; end
  endtask
  task done; insn_done = 1; step; insn_done = 0; step; endtask
  task t_ovr;
    for (k = 0; k < 4; k = k + 1) begin
      pfx({3'h1, k[1:0], 3'h6}); ins(10'h000);
      chk("seg", seg_sel, k);
      chk("mem", mem_operand, 1);
      ea_wait; chk("ea", i, 3);
      done; chk("pend", ovr_pending, 0);
    end
  endtask
  task t_str; pfx(8'h2E); ins(10'h001); chk("str", seg_sel, 0); ea_wait; done; endtask
  task t_frm;
    ins(10'h014); chk("frame", seg_sel, 2); ea_wait;
    step; ins(10'h00C); chk("direct", {direct_disp, seg_sel}, 7); ea_wait;
  endtask
  task t_reg;
    for (k = 0; k < 16; k = k + 1) begin
      step; ins({k[3:0], 2'h3, 4'h0});
      chk("reg", {reg_index, byte_sel, high_byte}, {k[3] ? k[2:0] : {1'b0, k[1:0]}, !k[3], !k[3] & k[2]});
      chk("regmem", {mem_operand, ea_busy}, 0);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst = 0;
    t_ovr; t_str; t_frm; t_reg; wrap_up;
  end
endmodule // testbench
